// ---- hw/sassq_regs.vh ----
// Register offsets, fields and timing constants of the scan sequencer
`ifndef SASSQ_REGS_VH
`define SASSQ_REGS_VH
`define SASSQ_CTRL_OFS      4'h0
`define SASSQ_CHEN_OFS      4'h1
`define SASSQ_DIFF_OFS      4'h2
`define SASSQ_SAMP_OFS      4'h3
`define SASSQ_LIMLO_OFS     4'h4
`define SASSQ_LIMHI_OFS     4'h5
`define SASSQ_STAT_OFS      4'h6
`define SASSQ_MASK_OFS      4'h7
`define SASSQ_RES0_OFS      4'h8
`define SASSQ_CTRL_EN_BIT   0
`define SASSQ_CTRL_CONT_BIT 1
`define SASSQ_CTRL_REF_LSB  2
`define SASSQ_CTRL_RST      4'h0
`define SASSQ_SAMP_RST      8'h02
`define SASSQ_LIMHI_RST     12'hFFF
`define SASSQ_IRQ_SCAN_BIT  0
`define SASSQ_IRQ_RANGE_BIT 1
`define SASSQ_REF_SUPPLY    2'h0
`define SASSQ_REF_HALF      2'h1
`define SASSQ_REF_TRIM      2'h2
`define SASSQ_REF_EXT       2'h3
`define SASSQ_RES_BITS      12
`define SASSQ_NCH           8
`define SASSQ_CONV_CLK_MHZ  18
`define SASSQ_CONV_CLKS     18
`define SASSQ_SYS_CLK_MHZ   100
`define SASSQ_CONV_CYC      ((`SASSQ_CONV_CLKS*`SASSQ_SYS_CLK_MHZ+`SASSQ_CONV_CLK_MHZ-1)/`SASSQ_CONV_CLK_MHZ)
`define SASSQ_MSPS_NS       1000
`define SASSQ_SLOT_CYC      (`SASSQ_MSPS_NS*`SASSQ_SYS_CLK_MHZ/1000)
`endif

// ---- hw/sassq_top.v ----
// SAR ADC scan sequencer with Avalon-MM registers and interrupt
//
// Design decisions made here: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
module sassq_top (
  input  wire        sys_clk_in,
  input  wire        reset_in,
  input  wire        clk_en_in,
  input  wire [3:0]  avs_address_in,
  input  wire        avs_read_in,
  input  wire        avs_write_in,
  input  wire [31:0] avs_writedata_in,
  output reg  [31:0] avs_readdata_out,
  output reg         avs_waitrequest_out,
  input  wire        low_power_in,
  input  wire        adc_bit_in,
  output reg         adc_sample_out,
  output reg         adc_convert_out,
  output reg  [2:0]  adc_channel_out,
  output reg         adc_diff_out,
  output reg  [1:0]  adc_ref_sel_out,
  output reg  [11:0] adc_trial_out,
  output reg         irq_out
);
`include "sassq_regs.vh"

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SAMP = 3'b010;
  localparam [2:0] ST_CONV = 3'b100;
  localparam integer CONV_CYC_I = `SASSQ_CONV_CYC;
  localparam integer SLOT_CYC_I = `SASSQ_SLOT_CYC;
  localparam [7:0]   CONV_CYC   = CONV_CYC_I[7:0];
  localparam [7:0]   SLOT_CYC   = SLOT_CYC_I[7:0];
  localparam [7:0]   CONV_STEP  = CONV_CYC / 8'd12;

  // Twelve decisions of CONV_STEP + 1 cycles keep a conversion above
  // eighteen converter clocks; the slot counter spaces conversion
  // starts so the aggregate rate never exceeds one per microsecond.

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [3:0]  ctrl_ff;
  reg [7:0]  chen_ff;
  reg [7:0]  diff_ff;
  reg [7:0]  samp_ff;
  reg [11:0] limlo_ff;
  reg [11:0] limhi_ff;
  reg [1:0]  stat_ff;
  reg [1:0]  mask_ff;
  reg [11:0] res_ff [0:`SASSQ_NCH-1];
  reg        ack_ff;

  // Two-flop synchronisers for outside pins
  reg        lp_s1_ff;
  reg        lp_s2_ff;
  reg        bit_s1_ff;
  reg        bit_s2_ff;

  // Sequencer state
  reg [2:0]  state_ff;
  reg [2:0]  chan_ff;
  reg [7:0]  cnt_ff;
  reg [7:0]  slot_ff;
  reg [3:0]  bitn_ff;
  reg [7:0]  step_ff;
  reg [11:0] sar_ff;
  reg [7:0]  done_ff;

  wire       bus_req = avs_read_in | avs_write_in;
  wire       wr_en   = avs_write_in & ack_ff;
  wire       run_ok  = ctrl_ff[`SASSQ_CTRL_EN_BIT] & ~lp_s2_ff;
  wire       bus_take = bus_req & ~ack_ff;

  // Final result and the cycle of the last bit decision
  wire [11:0] fin_res  = {sar_ff[11:1], bit_s2_ff};
  wire        last_bit = (state_ff == ST_CONV) && (step_ff == 8'd0) &&
                         (bitn_ff == 4'd0);
  wire        stat_wr  = wr_en && (avs_address_in == `SASSQ_STAT_OFS);
  wire [1:0]  stat_clr = stat_wr ? avs_writedata_in[1:0] : 2'h0;
  wire        res_wr   = clk_en_in && last_bit;
  wire [7:0]  rot_en;
  reg  [31:0] nxt_rdata;
  genvar      g;

  reg        ev_scan;
  reg        ev_range;
  reg [2:0]  nxt_chan;
  reg        nxt_found;
  integer    i;

  // Enable flags rotated so that bit k is channel chan_ff + k + 1
  generate
    for (g = 0; g < `SASSQ_NCH; g = g + 1) begin : g_rot
      localparam integer OFS_I = (g + 1) % `SASSQ_NCH;
      localparam [2:0]   OFS   = OFS_I[2:0];
      wire       [2:0]   idx   = chan_ff + OFS;
      assign rot_en[g] = chen_ff[idx];
    end
  endgenerate

  // Next enabled channel after the current one, wrapping
  always @* begin
    nxt_chan  = chan_ff;
    nxt_found = 1'b0;
    for (i = 0; i < `SASSQ_NCH; i = i + 1) begin
      if (!nxt_found && rot_en[i]) begin
        nxt_chan  = chan_ff + i[2:0] + 3'h1;
        nxt_found = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  // Low power and the comparator are asynchronous to this clock; only
  // the second stage is read by the logic.
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      lp_s1_ff  <= 1'b0;
      lp_s2_ff  <= 1'b0;
      bit_s1_ff <= 1'b0;
      bit_s2_ff <= 1'b0;
    end else if (clk_en_in) begin
      lp_s1_ff  <= low_power_in;
      lp_s2_ff  <= lp_s1_ff;
      bit_s1_ff <= adc_bit_in;
      bit_s2_ff <= bit_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle, then ack
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      ack_ff              <= 1'b0;
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0000_0000;
    end else if (clk_en_in) begin
      // Ack lasts one cycle so a held request is not taken twice
      ack_ff              <= bus_take;
      avs_waitrequest_out <= ~bus_take;
      if (bus_take) begin
        avs_readdata_out <= nxt_rdata;
      end
    end
  end

  // Read data for the addressed register
  always @* begin
    nxt_rdata = 32'h0000_0000;
    case (avs_address_in)
      `SASSQ_CTRL_OFS:  nxt_rdata[3:0]  = ctrl_ff;
      `SASSQ_CHEN_OFS:  nxt_rdata[7:0]  = chen_ff;
      `SASSQ_DIFF_OFS:  nxt_rdata[7:0]  = diff_ff;
      `SASSQ_SAMP_OFS:  nxt_rdata[7:0]  = samp_ff;
      `SASSQ_LIMLO_OFS: nxt_rdata[11:0] = limlo_ff;
      `SASSQ_LIMHI_OFS: nxt_rdata[11:0] = limhi_ff;
      `SASSQ_STAT_OFS:  nxt_rdata[1:0]  = stat_ff;
      `SASSQ_MASK_OFS:  nxt_rdata[1:0]  = mask_ff;
      default: begin
        if (avs_address_in[3]) begin
          nxt_rdata[11:0] = res_ff[avs_address_in[2:0]];
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result buffers, one per channel, written at the last bit decision
  generate
    for (g = 0; g < `SASSQ_NCH; g = g + 1) begin : g_res
      always @(posedge sys_clk_in) begin
        if (reset_in) begin
          res_ff[g] <= 12'h000;
        end else if (res_wr && chan_ff == g) begin
          res_ff[g] <= fin_res;
        end
      end
    end
  endgenerate

  // Control registers
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      ctrl_ff  <= `SASSQ_CTRL_RST;
      chen_ff  <= 8'h00;
      diff_ff  <= 8'h00;
      samp_ff  <= `SASSQ_SAMP_RST;
      limlo_ff <= 12'h000;
      limhi_ff <= `SASSQ_LIMHI_RST;
      mask_ff  <= 2'h0;
    end else if (clk_en_in && wr_en) begin
      case (avs_address_in)
        `SASSQ_CTRL_OFS:  ctrl_ff  <= avs_writedata_in[3:0];
        `SASSQ_CHEN_OFS:  chen_ff  <= avs_writedata_in[7:0];
        `SASSQ_DIFF_OFS:  diff_ff  <= avs_writedata_in[7:0];
        `SASSQ_SAMP_OFS:  samp_ff  <= avs_writedata_in[7:0];
        `SASSQ_LIMLO_OFS: limlo_ff <= avs_writedata_in[11:0];
        `SASSQ_LIMHI_OFS: limhi_ff <= avs_writedata_in[11:0];
        `SASSQ_MASK_OFS:  mask_ff  <= avs_writedata_in[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, set wins over write-one-to-clear
  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      stat_ff <= 2'h0;
      irq_out <= 1'b0;
    end else if (clk_en_in) begin
      stat_ff <= (stat_ff & ~stat_clr) | {ev_range, ev_scan};
      irq_out <= |(stat_ff & mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  always @* begin
    ev_scan  = 1'b0;
    ev_range = 1'b0;
    if (last_bit) begin
      ev_range = (fin_res < limlo_ff) || (fin_res > limhi_ff);
      ev_scan  = ((done_ff | (8'h01 << chan_ff)) & chen_ff) == chen_ff;
    end
  end

  always @(posedge sys_clk_in) begin
    if (reset_in) begin
      state_ff        <= ST_IDLE;
      chan_ff         <= 3'h0;
      cnt_ff          <= 8'h00;
      slot_ff         <= 8'h00;
      bitn_ff         <= 4'h0;
      step_ff         <= 8'h00;
      sar_ff          <= 12'h000;
      done_ff         <= 8'h00;
      adc_sample_out  <= 1'b0;
      adc_convert_out <= 1'b0;
      adc_channel_out <= 3'h0;
      adc_diff_out    <= 1'b0;
      adc_ref_sel_out <= 2'h0;
      adc_trial_out   <= 12'h000;
    end else if (clk_en_in) begin
      adc_ref_sel_out <= ctrl_ff[`SASSQ_CTRL_REF_LSB +: 2];
      slot_ff <= (slot_ff == 8'd0) ? 8'd0 : slot_ff - 8'd1;
      case (state_ff)
        ST_IDLE: begin
          adc_sample_out  <= 1'b0;
          adc_convert_out <= 1'b0;
          done_ff         <= 8'h00;
          if (run_ok && chen_ff != 8'h00) begin
            chan_ff         <= nxt_chan;
            adc_channel_out <= nxt_chan;
            adc_diff_out    <= diff_ff[nxt_chan];
            cnt_ff          <= samp_ff;
            adc_sample_out  <= 1'b1;
            state_ff        <= ST_SAMP;
          end
        end
        ST_SAMP: begin
          if (!run_ok) begin
            adc_sample_out <= 1'b0;
            state_ff       <= ST_IDLE;
          end else if (cnt_ff != 8'd0) begin
            cnt_ff <= cnt_ff - 8'd1;
          end else if (slot_ff == 8'd0) begin
            adc_sample_out  <= 1'b0;
            adc_convert_out <= 1'b1;
            slot_ff         <= SLOT_CYC - 8'd1;
            bitn_ff         <= 4'd11;
            step_ff         <= CONV_STEP;
            sar_ff          <= 12'h800;
            adc_trial_out   <= 12'h800;
            state_ff        <= ST_CONV;
          end
        end
        ST_CONV: begin
          // Each decision waits for the comparator to pass both
          // synchroniser stages after the trial word changes.
          // minimum conversion length
          if (step_ff != 8'd0) begin
            step_ff <= step_ff - 8'd1;
          end else begin
            sar_ff[bitn_ff] <= bit_s2_ff;
            if (bitn_ff != 4'd0) begin
              sar_ff[bitn_ff - 4'd1]        <= 1'b1;
              adc_trial_out                 <= sar_ff;
              adc_trial_out[bitn_ff]        <= bit_s2_ff;
              adc_trial_out[bitn_ff - 4'd1] <= 1'b1;
              bitn_ff                       <= bitn_ff - 4'd1;
              step_ff                       <= CONV_STEP;
            end else begin
              adc_convert_out <= 1'b0;
              done_ff         <= ev_scan ? 8'h00
                                 : done_ff | (8'h01 << chan_ff);
              if (run_ok && (!ev_scan || ctrl_ff[`SASSQ_CTRL_CONT_BIT])
                  && chen_ff != 8'h00) begin
                chan_ff         <= nxt_chan;
                adc_channel_out <= nxt_chan;
                adc_diff_out    <= diff_ff[nxt_chan];
                cnt_ff          <= samp_ff;
                adc_sample_out  <= 1'b1;
                state_ff        <= ST_SAMP;
              end else begin
                state_ff <= ST_IDLE;
              end
            end
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // sassq_top

// ---- tb/sassq_properties.sv ----
// Port-level checks of the scan sequencer
`timescale 1ns/1ns
module sassq_properties (
  input wire        sys_clk_in,
  input wire        reset_in,
  input wire        clk_en_in,
  input wire [3:0]  avs_address_in,
  input wire        avs_read_in,
  input wire        avs_write_in,
  input wire [31:0] avs_writedata_in,
  input wire [31:0] avs_readdata_out,
  input wire        avs_waitrequest_out,
  input wire        low_power_in,
  input wire        adc_bit_in,
  input wire        adc_sample_out,
  input wire        adc_convert_out,
  input wire [2:0]  adc_channel_out,
  input wire        adc_diff_out,
  input wire [1:0]  adc_ref_sel_out,
  input wire [11:0] adc_trial_out,
  input wire        irq_out
);
  reg [7:0] gap_ff;
  reg [7:0] len_ff;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  // Cycles since the last conversion start, saturating
  always @(posedge sys_clk_in) begin
    if (reset_in) gap_ff <= 8'hFF;
    else if ($rose(adc_convert_out)) gap_ff <= 8'h00;
    else if (gap_ff != 8'hFF) gap_ff <= gap_ff + 8'h01;
    if (!adc_convert_out) len_ff <= 8'h00;
    else if (len_ff != 8'hFF) len_ff <= len_ff + 8'h01;
  end
  AST_START_SPACING: assert property (
    $rose(adc_convert_out) |-> gap_ff >= 8'h63)
    else $error("conversion starts closer than one microsecond");
  AST_CONV_LENGTH: assert property (
    $fell(adc_convert_out) |-> len_ff >= 8'h64)
    else $error("conversion shorter than eighteen converter clocks");
  AST_SAMPLE_FIRST: assert property (
    $rose(adc_convert_out) |-> $past(adc_sample_out))
    else $error("conversion began without a sample window");
  AST_PHASE_EXCL: assert property (
    !(adc_sample_out && adc_convert_out))
    else $error("sample and convert active together");
  AST_CHAN_HOLD: assert property (
    adc_convert_out && $past(adc_convert_out) |->
      $stable(adc_channel_out) && $stable(adc_diff_out))
    else $error("channel or mode changed during conversion");
  AST_LOW_POWER: assert property (
    low_power_in [*4] |-> !$rose(adc_convert_out))
    else $error("conversion started in low power");
  AST_WAIT_ONE:
    assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_CAUSE: assert property (
    $fell(avs_waitrequest_out) |-> $past(avs_read_in || avs_write_in))
    else $error("bus acknowledge without a request");
  AST_RESET_STATE: assert property (
    $fell(reset_in) |-> avs_waitrequest_out && !irq_out && !adc_convert_out)
    else $error("outputs not at reset state");
  cover property ($rose(adc_convert_out));
  cover property ($rose(irq_out));
  cover property (!avs_waitrequest_out && avs_read_in);
endmodule // sassq_properties
bind sassq_top sassq_properties u_props (.*);

// ---- tb/sassq_analog_model.sv ----
// Analog inputs seen through the comparator
`timescale 1ns/1ns
module sassq_analog_model (
  input  wire        sys_clk_in,
  input  wire        adc_convert_in,
  input  wire [2:0]  adc_channel_in,
  input  wire [11:0] adc_trial_in,
  output reg         adc_bit_out
);
  reg         idle_ff = 1'b0;
  wire [11:0] level = {1'b0, adc_channel_in, 8'hA5};
  always @(posedge sys_clk_in) idle_ff <= ~idle_ff;
  // Comparator is meaningless outside a conversion
  always @* adc_bit_out = adc_convert_in ? (level >= adc_trial_in) : idle_ff;
endmodule // sassq_analog_model

// ---- tb/sassq_tb_top.sv ----
// Register-level testbench of the scan sequencer
`timescale 1ns/1ns
module sassq_tb_top;
  reg sys_clk_in, reset_in, clk_en_in, avs_read_in, avs_write_in;
  reg low_power_in;
  reg [3:0] avs_address_in;
  reg [31:0] avs_writedata_in, q;
  wire [31:0] avs_readdata_out;
  wire avs_waitrequest_out, adc_bit_in, adc_sample_out, adc_convert_out;
  wire adc_diff_out, irq_out;
  wire [2:0] adc_channel_out;
  wire [1:0] adc_ref_sel_out;
  wire [11:0] adc_trial_out;
  integer mismatches, comparisons, i, n_w;
  sassq_top dut (.*);
  sassq_analog_model partner (
    .sys_clk_in     (sys_clk_in),
    .adc_convert_in (adc_convert_out),
    .adc_channel_in (adc_channel_out),
    .adc_trial_in   (adc_trial_out),
    .adc_bit_out    (adc_bit_in)
  );
  ////////////////////////////////////////////////////////////////////
  task tally_and_finish;
    begin
      if (mismatches == 0 && comparisons > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("BAD %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge sys_clk_in);
      avs_address_in <= a;
      avs_writedata_in <= d;
      avs_read_in <= !w;
      avs_write_in <= w;
      n = 0;
      @(posedge sys_clk_in);
      while (avs_waitrequest_out !== 1'b0 && n < 40) begin
        @(posedge sys_clk_in);
        n = n + 1;
      end
      q = avs_readdata_out;
      avs_read_in <= 1'b0;
      avs_write_in <= 1'b0;
      if (n == 40) begin
        mismatches = mismatches + 1;
        tally_and_finish;
      end
    end
  endtask
  task wait_irq;
    integer n;
    begin
      n = 0;
      while (irq_out !== 1'b1 && n < 5000) begin
        @(posedge sys_clk_in);
        n = n + 1;
      end
      if (n == 5000) begin
        mismatches = mismatches + 1;
        tally_and_finish;
      end
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    reset_in <= 1'b1;
    clk_en_in <= 1'b1;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
    avs_address_in <= 4'h0;
    avs_writedata_in <= 32'h0;
    low_power_in <= 1'b0;
    mismatches = 0;
    comparisons = 0;
    repeat (10) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      bus(0, i, 0);
      chk("reset", (i == 3) ? 32'h2 : (i == 5) ? 32'hFFF : 32'h0, q);
    end
    for (i = 0; i < 4; i = i + 1) begin
      bus(1, 4'h0, i << 2);
      repeat (3) @(posedge sys_clk_in);
      chk("refsel", i, {30'h0, adc_ref_sel_out});
    end
    bus(1, 4'h1, 32'h85);
    bus(1, 4'h2, 32'h04);
    bus(1, 4'h7, 32'h1);
    bus(1, 4'h0, 32'h9);
    wait_irq;
    bus(0, 4'h6, 0);
    chk("status", 32'h1, q);
    for (i = 2; i < 8; i = i + 5) begin
      n_w = 0;
      while (!(adc_convert_out === 1'b1 && adc_channel_out === i[2:0])
             && n_w < 1000) begin
        @(posedge sys_clk_in);
        n_w = n_w + 1;
      end
      chk("chan_wait", 32'h0, (n_w == 1000));
      chk("diff", (i == 2), {31'h0, adc_diff_out});
    end
    clk_en_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    q = {20'h0, adc_trial_out};
    repeat (30) @(posedge sys_clk_in);
    chk("freeze", q, {20'h0, adc_trial_out});
    clk_en_in <= 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      bus(0, 8 + i, 0);
      chk("result", ((8'h85 >> i) & 1) ? {i[3:0], 8'hA5} : 0, q);
    end
    bus(1, 4'h8, 32'h0);
    bus(0, 4'h8, 0);
    chk("result0", 32'h0A5, q);
    bus(1, 4'h0, 32'h0);
    repeat (400) @(posedge sys_clk_in);
    bus(1, 4'h6, 32'h3);
    bus(0, 4'h6, 0);
    chk("clear", 32'h0, q);
    repeat (3) @(posedge sys_clk_in);
    chk("irq", 32'h0, {31'h0, irq_out});
    bus(1, 4'h4, 32'h200);
    bus(1, 4'h1, 32'h01);
    bus(1, 4'h7, 32'h2);
    bus(1, 4'h0, 32'h1);
    wait_irq;
    bus(0, 4'h6, 0);
    chk("range", 32'h3, q);
    bus(1, 4'h0, 32'h0);
    repeat (400) @(posedge sys_clk_in);
    low_power_in <= 1'b1;
    bus(1, 4'h6, 32'h3);
    bus(1, 4'h7, 32'h3);
    bus(1, 4'h0, 32'h1);
    repeat (500) @(posedge sys_clk_in);
    bus(0, 4'h6, 0);
    chk("sleep", 32'h0, q);
    low_power_in <= 1'b0;
    wait_irq;
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    bus(0, 4'h0, 0);
    chk("rereset", 32'h0, q);
    tally_and_finish;
  end
endmodule // sassq_tb_top
